/* File: rtl/ppfm_port_mux.sv */
/*
 * Pin function multiplexer for port A lines 0-3 and port B line 0.
 * Assumes pin inputs are asynchronous to core_clk, configuration comes from
 * core_clk logic, and spi_link_clk is the host's SPI clock on port A line 1.
 */
// Summary of operation
// - port B line 0 is bidirectional I/O with switchable pull-up
// - port B line 0 may instead go to timer channel 0 or analog input 3
// - port A pull-down only while that line's wake-up is enabled
// - port A line n feeds key-wake input bit n
// - with SPI on, port A line 3 drives serial data to the host
// - with SPI on, port A line 2 takes serial data from the host
// - with SPI on, port A line 1 is the host's SPI clock
// - with SPI on, port A line 0 is the active-low client select
// - port A line 0 is I/O with pull-up or pull-down and optional wake
// - port A line 0 may serve as the external interrupt request input
// - with SPI off, a low select level raises an internal wake request
`timescale 1ns/10ps
`default_nettype none
module ppfm_port_mux (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic spi_link_clk,
    input wire logic spi_enable,
    input wire logic irq_enable,
    input wire ppfm_pkg::ppfm_pa_cfg_type porta_cfg [ppfm_pkg::NUM_PA_LINES],
    input wire ppfm_pkg::ppfm_pb_cfg_type portb_cfg,
    input wire logic spi_serial_out,
    input wire logic timer_channel0_out,
    input wire logic timer_channel0_oe,
    input wire logic [ppfm_pkg::NUM_PA_LINES-1:0] porta_line_in,
    output logic [ppfm_pkg::NUM_PA_LINES-1:0] porta_line_out,
    output logic [ppfm_pkg::NUM_PA_LINES-1:0] porta_line_oe_n,
    output logic [ppfm_pkg::NUM_PA_LINES-1:0] porta_pullup,
    output logic [ppfm_pkg::NUM_PA_LINES-1:0] porta_pulldown,
    input wire logic portb_line0_in,
    output logic portb_line0_out,
    output logic portb_line0_oe_n,
    output logic portb_pullup,
    output logic analog_input3_sel,
    output logic [ppfm_pkg::NUM_PA_LINES-1:0] porta_read,
    output logic portb_read,
    output logic [ppfm_pkg::NUM_PA_LINES-1:0] key_wake_input,
    output logic irq_request,
    output logic wake_request,
    output logic spi_select_n,
    output logic timer_channel0_in,
    output logic [ppfm_pkg::BYTE_BITS-1:0] spi_rx_byte,
    output logic spi_rx_valid
);
    localparam int NL = ppfm_pkg::NUM_PA_LINES;
    localparam int BB = ppfm_pkg::BYTE_BITS;

    ////////////////////////////////////////////////////////////////////////
    // link domain: shift in host data on the SPI clock
    logic frame_idle;
    logic link_clear;
    logic [ppfm_pkg::CNT_W-1:0] bit_cnt_r;
    logic [ppfm_pkg::CNT_W-1:0] bit_cnt_nxt;
    logic [BB-1:0] shift_r;
    logic [BB-1:0] shift_nxt;
    logic [BB-1:0] link_byte_r;
    logic [BB-1:0] link_byte_nxt;
    logic link_tog_r;
    logic link_tog_nxt;

    // the frame's own select ends a partial byte, since the clock stops
    assign frame_idle = ~spi_enable | porta_line_in[ppfm_pkg::SEL_LINE];
    assign link_clear = frame_idle | ~reset_n;

    always_comb begin
        shift_nxt = {shift_r[BB-2:0],
                     porta_line_in[ppfm_pkg::SIN_LINE]};
        bit_cnt_nxt = bit_cnt_r + ppfm_pkg::CNT_STEP;
        link_byte_nxt = link_byte_r;
        link_tog_nxt = link_tog_r;
        if (bit_cnt_r == ppfm_pkg::CNT_LAST) begin
            link_byte_nxt = shift_nxt;
            link_tog_nxt = ~link_tog_r;
        end
    end

    // clocked by the host's SPI clock on line 1
    always_ff @(posedge spi_link_clk or posedge link_clear) begin
        if (link_clear) begin
            bit_cnt_r <= ppfm_pkg::CNT_ZERO;
            shift_r <= ppfm_pkg::BYTE_RST;
        end else begin
            bit_cnt_r <= bit_cnt_nxt;
            shift_r <= shift_nxt;
        end
    end

    // byte and toggle survive the frame end so the core can still take them
    always_ff @(posedge spi_link_clk or negedge reset_n) begin
        if (!reset_n) begin
            link_byte_r <= ppfm_pkg::BYTE_RST;
            link_tog_r <= 1'b0;
        end else begin
            link_byte_r <= link_byte_nxt;
            link_tog_r <= link_tog_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // core domain: synchronisers
    logic [NL-1:0] pa_meta_r;
    logic [NL-1:0] pa_sync_r;
    logic pb_meta_r;
    logic pb_sync_r;
    logic tog_meta_r;
    logic tog_sync_r;
    logic tog_seen_r;

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            pa_meta_r <= ppfm_pkg::PA_RELEASED;
            pa_sync_r <= ppfm_pkg::PA_RELEASED;
            pb_meta_r <= 1'b1;
            pb_sync_r <= 1'b1;
            tog_meta_r <= 1'b0;
            tog_sync_r <= 1'b0;
        end else if (clk_en) begin
            pa_meta_r <= porta_line_in;
            pa_sync_r <= pa_meta_r;
            pb_meta_r <= portb_line0_in;
            pb_sync_r <= pb_meta_r;
            tog_meta_r <= link_tog_r;
            tog_sync_r <= tog_meta_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // core domain: per-line port A pad control
    logic sel_low;
    logic [NL-1:0] pa_out_nxt;
    logic [NL-1:0] pa_oe_n_nxt;
    logic [NL-1:0] pa_pu_nxt;
    logic [NL-1:0] pa_pd_nxt;
    logic [NL-1:0] kw_nxt;

    assign sel_low = ~pa_sync_r[ppfm_pkg::SEL_LINE];

    genvar gi;
    generate
        for (gi = 0; gi < NL; gi++) begin : g_pa
            logic is_sout;
            assign is_sout = (gi == ppfm_pkg::SOUT_LINE);
            // client out value whenever SPI is enabled; the pad drives it only while selected
            assign pa_out_nxt[gi] = (spi_enable && is_sout) ?
                spi_serial_out : porta_cfg[gi].out_val;
            // spi lines become inputs, serial out driven while selected, else software direction
            assign pa_oe_n_nxt[gi] = spi_enable ?
                ~(is_sout & sel_low) : ~porta_cfg[gi].drive;
            // pull-down only with wake-up enabled
            assign pa_pd_nxt[gi] = porta_cfg[gi].pull_en &
                porta_cfg[gi].pull_down & porta_cfg[gi].wake_en;
            assign pa_pu_nxt[gi] = porta_cfg[gi].pull_en & ~pa_pd_nxt[gi];
            // line n to key-wake bit n, idle while SPI owns it
            assign kw_nxt[gi] = porta_cfg[gi].wake_en & ~spi_enable &
                pa_sync_r[gi];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // core domain: registered outputs
    logic [NL-1:0] pa_out_r;
    logic [NL-1:0] pa_oe_n_r;
    logic [NL-1:0] pa_pu_r;
    logic [NL-1:0] pa_pd_r;
    logic [NL-1:0] kw_r;
    logic pb_out_r;
    logic pb_out_nxt;
    logic pb_oe_n_r;
    logic pb_oe_n_nxt;
    logic pb_pu_r;
    logic pb_pu_nxt;
    logic adc_sel_r;
    logic adc_sel_nxt;
    logic tmr_in_r;
    logic tmr_in_nxt;
    logic irq_r;
    logic irq_nxt;
    logic wake_r;
    logic wake_nxt;
    logic sel_n_r;
    logic sel_n_nxt;
    logic [BB-1:0] rx_byte_r;
    logic [BB-1:0] rx_byte_nxt;
    logic rx_valid_r;
    logic rx_valid_nxt;
    logic tog_seen_nxt;

    always_comb begin
        pb_out_nxt = portb_cfg.out_val;
        pb_oe_n_nxt = ~portb_cfg.drive;
        pb_pu_nxt = portb_cfg.pull_en;
        adc_sel_nxt = 1'b0;
        tmr_in_nxt = 1'b0;
        case (portb_cfg.func)
            ppfm_pkg::PPFM_PB_GPIO: begin
            end
            ppfm_pkg::PPFM_PB_TIMER: begin
                pb_out_nxt = timer_channel0_out;
                pb_oe_n_nxt = ~timer_channel0_oe;
                tmr_in_nxt = pb_sync_r;
            end
            ppfm_pkg::PPFM_PB_ADC: begin
                // pad released and pull off so the analog level is clean
                pb_oe_n_nxt = 1'b1;
                pb_pu_nxt = 1'b0;
                adc_sel_nxt = 1'b1;
            end
            default: begin
                pb_oe_n_nxt = 1'b1;
                pb_pu_nxt = 1'b0;
            end
        endcase
        // external interrupt input on line 0, active low
        irq_nxt = irq_enable & ~spi_enable & sel_low;
        // level wake, no edge needed
        wake_nxt = ~spi_enable & sel_low;
        sel_n_nxt = ~(spi_enable & sel_low);
        tog_seen_nxt = tog_sync_r;
        rx_valid_nxt = tog_sync_r ^ tog_seen_r;
        // link byte holds for eight host clocks, ample for the sync delay
        rx_byte_nxt = rx_valid_nxt ? link_byte_r : rx_byte_r;
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            pa_out_r <= ppfm_pkg::PA_ZERO;
            pa_oe_n_r <= ppfm_pkg::PA_RELEASED;
            pa_pu_r <= ppfm_pkg::PA_ZERO;
            pa_pd_r <= ppfm_pkg::PA_ZERO;
            kw_r <= ppfm_pkg::PA_ZERO;
            pb_out_r <= 1'b0;
            pb_oe_n_r <= 1'b1;
            pb_pu_r <= 1'b0;
            adc_sel_r <= 1'b0;
            tmr_in_r <= 1'b0;
            irq_r <= 1'b0;
            wake_r <= 1'b0;
            sel_n_r <= 1'b1;
            tog_seen_r <= 1'b0;
            rx_valid_r <= 1'b0;
            rx_byte_r <= ppfm_pkg::BYTE_RST;
        end else if (clk_en) begin
            pa_out_r <= pa_out_nxt;
            pa_oe_n_r <= pa_oe_n_nxt;
            pa_pu_r <= pa_pu_nxt;
            pa_pd_r <= pa_pd_nxt;
            kw_r <= kw_nxt;
            pb_out_r <= pb_out_nxt;
            pb_oe_n_r <= pb_oe_n_nxt;
            pb_pu_r <= pb_pu_nxt;
            adc_sel_r <= adc_sel_nxt;
            tmr_in_r <= tmr_in_nxt;
            irq_r <= irq_nxt;
            wake_r <= wake_nxt;
            sel_n_r <= sel_n_nxt;
            tog_seen_r <= tog_seen_nxt;
            rx_valid_r <= rx_valid_nxt;
            rx_byte_r <= rx_byte_nxt;
        end
    end

    assign porta_line_out = pa_out_r;
    assign porta_line_oe_n = pa_oe_n_r;
    assign porta_pullup = pa_pu_r;
    assign porta_pulldown = pa_pd_r;
    assign key_wake_input = kw_r;
    assign porta_read = pa_sync_r;
    assign portb_line0_out = pb_out_r;
    assign portb_line0_oe_n = pb_oe_n_r;
    assign portb_pullup = pb_pu_r;
    assign analog_input3_sel = adc_sel_r;
    assign portb_read = pb_sync_r;
    assign timer_channel0_in = tmr_in_r;
    assign irq_request = irq_r;
    assign wake_request = wake_r;
    assign spi_select_n = sel_n_r;
    assign spi_rx_byte = rx_byte_r;
    assign spi_rx_valid = rx_valid_r;
endmodule
`default_nettype wire

/* File: pkg/ppfm_pkg.sv */
/*
 * Constants and carriers for the port pin function multiplexer.
 * Assumes a single core clock domain for configuration and one link clock
 * supplied by the external SPI host.
 */
`default_nettype none
package ppfm_pkg;
    localparam int NUM_PA_LINES = 4;
    localparam int BYTE_BITS = 8;
    localparam int CNT_W = 3;
    // port A line roles while the client SPI is enabled
    localparam int SEL_LINE = 0;
    localparam int CLK_LINE = 1;
    localparam int SIN_LINE = 2;
    localparam int SOUT_LINE = 3;
    localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;
    localparam logic [CNT_W-1:0] CNT_LAST = 3'h7;
    localparam logic [CNT_W-1:0] CNT_STEP = 3'h1;
    localparam logic [BYTE_BITS-1:0] BYTE_RST = 8'h00;
    localparam logic [NUM_PA_LINES-1:0] PA_ZERO = 4'h0;
    localparam logic [NUM_PA_LINES-1:0] PA_RELEASED = 4'hF;

    typedef enum logic [1:0] {
        PPFM_PB_GPIO,
        PPFM_PB_TIMER,
        PPFM_PB_ADC
    } ppfm_pb_func_type;

    typedef struct packed {
        logic out_val;
        logic drive;
        logic pull_en;
        logic pull_down;
        logic wake_en;
    } ppfm_pa_cfg_type;

    typedef struct packed {
        logic out_val;
        logic drive;
        logic pull_en;
        ppfm_pb_func_type func;
    } ppfm_pb_cfg_type;
endpackage
`default_nettype wire

/* File: testbench/ppfm_port_mux_asserts.sv */
/* checker for the port pin function multiplexer.
   assumes only the top module's ports; bound in below. */
`timescale 1ns/10ps
`default_nettype none
module ppfm_port_mux_asserts (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic spi_enable,
    input wire logic irq_enable,
    input wire ppfm_pkg::ppfm_pa_cfg_type porta_cfg [ppfm_pkg::NUM_PA_LINES],
    input wire ppfm_pkg::ppfm_pb_cfg_type portb_cfg,
    input wire logic [ppfm_pkg::NUM_PA_LINES-1:0] porta_line_in,
    input wire logic [ppfm_pkg::NUM_PA_LINES-1:0] porta_line_oe_n,
    input wire logic [ppfm_pkg::NUM_PA_LINES-1:0] porta_pulldown,
    input wire logic [ppfm_pkg::NUM_PA_LINES-1:0] key_wake_input,
    input wire logic portb_line0_oe_n,
    input wire logic analog_input3_sel,
    input wire logic irq_request,
    input wire logic wake_request,
    input wire logic spi_select_n
);
    logic [3:0] pd_ok;
    logic [3:0] wk_ok;

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pd_ok[i] = porta_cfg[i].pull_en & porta_cfg[i].pull_down
                & porta_cfg[i].wake_en;
            wk_ok[i] = porta_cfg[i].wake_en & ~spi_enable;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    property p_pd_gate;
        clk_en |=> (porta_pulldown & ~$past(pd_ok)) == 4'h0;
    endproperty
    a_pd_gate: assert property (p_pd_gate)
        else $error("pull-down without wake");

    property p_kw_mask;
        clk_en |=> (key_wake_input & ~$past(wk_ok)) == 4'h0;
    endproperty
    a_kw_mask: assert property (p_kw_mask)
        else $error("key-wake leak");

    property p_spi_in;
        clk_en && spi_enable |=> porta_line_oe_n[2:0] == 3'h7;
    endproperty
    a_spi_in: assert property (p_spi_in)
        else $error("spi input driven");

    property p_sout;
        clk_en && spi_enable |=> porta_line_oe_n[3] == spi_select_n;
    endproperty
    a_sout: assert property (p_sout)
        else $error("serial out enable");

    property p_sel_off;
        clk_en && !spi_enable |=> spi_select_n;
    endproperty
    a_sel_off: assert property (p_sel_off)
        else $error("select while off");

    // two sync flops plus the output flop: three low samples are enough
    property p_wake;
        (clk_en && !spi_enable && !porta_line_in[0]) [*3] |=> wake_request;
    endproperty
    a_wake: assert property (p_wake)
        else $error("no wake on low");

    property p_irq_off;
        clk_en && !irq_enable |=> !irq_request;
    endproperty
    a_irq_off: assert property (p_irq_off)
        else $error("irq while off");

    property p_adc;
        clk_en && portb_cfg.func == ppfm_pkg::PPFM_PB_ADC
            |=> analog_input3_sel && portb_line0_oe_n;
    endproperty
    a_adc: assert property (p_adc)
        else $error("analog route");
endmodule
bind ppfm_port_mux ppfm_port_mux_asserts ppfm_port_mux_asserts_inst (
    .core_clk, .reset_n, .clk_en, .spi_enable, .irq_enable, .porta_cfg,
    .portb_cfg, .porta_line_in, .porta_line_oe_n, .porta_pulldown,
    .key_wake_input, .portb_line0_oe_n, .analog_input3_sel, .irq_request,
    .wake_request, .spi_select_n
);
`default_nettype wire

/* File: testbench/ppfm_spi_host.sv */
/* host-side SPI server model driving select, clock and serial data.
   assumes the bench routes its pins onto port A lines 0 to 2. */
`timescale 1ns/10ps
`default_nettype none
module ppfm_spi_host (
    output logic sclk,
    output logic sel_n,
    output logic mosi
);
initial begin
    sclk = 1'b0; // stands still outside frames
    sel_n = 1'b1;
    mosi = 1'b0;
end
// n below 8 cuts the frame short, as a host abort would
task automatic send(input logic [7:0] b, input int n = 8);
    #30 sel_n = 1'b0;
    for (int i = 7; i > 7 - n; i--) begin
        mosi = b[i]; // msb first
        #24 sclk = 1'b1; // 48 ns link clock
        #24 sclk = 1'b0;
    end
    #24 sel_n = 1'b1;
    mosi = ~mosi; // released line must not hold the last bit
endtask
endmodule
`default_nettype wire

/* File: testbench/ppfm_port_mux_bench.sv */
/* self-checking bench for ppfm_port_mux with an SPI host model.
   assumes pads are plain levels: driven value, else the bench's pin; port A reads the pin alone with SPI off. */
`timescale 1ns/10ps
`default_nettype none
module ppfm_port_mux_bench;
logic core_clk, reset_n, spi_enable, irq_enable, so_bit, t_out, t_oe;
logic ce, pb_rd;
logic [3:0] pa_rd;
logic pb_pin, pb_out, pb_oe_n, pb_pu, adc, tin, irq, wake, sel_n, rx_v;
logic h_sclk, h_sel_n, h_mosi;
logic [3:0] pa_pin, pa_in, oe_n, pa_out, pu, pd, kw;
logic [7:0] rx_byte;
logic [7:0] rx_q [$];
ppfm_pkg::ppfm_pa_cfg_type pa_cfg [ppfm_pkg::NUM_PA_LINES];
ppfm_pkg::ppfm_pb_cfg_type pb_cfg;
int bad_count, checks;
assign pa_in = spi_enable ? {oe_n[3] ? pa_pin[3] : pa_out[3], h_mosi,
    h_sclk, h_sel_n} : pa_pin;
ppfm_spi_host ppfm_spi_host_inst (.sclk(h_sclk), .sel_n(h_sel_n),
    .mosi(h_mosi));
ppfm_port_mux ppfm_port_mux_inst (
    .core_clk(core_clk), .reset_n(reset_n), .clk_en(ce),
    .spi_link_clk(h_sclk), .spi_enable(spi_enable), .irq_enable(irq_enable),
    .porta_cfg(pa_cfg), .portb_cfg(pb_cfg), .spi_serial_out(so_bit),
    .timer_channel0_out(t_out), .timer_channel0_oe(t_oe),
    .porta_line_in(pa_in), .porta_line_out(pa_out), .porta_line_oe_n(oe_n),
    .porta_pullup(pu), .porta_pulldown(pd),
    .portb_line0_in(pb_oe_n ? pb_pin : pb_out), .portb_line0_out(pb_out),
    .portb_line0_oe_n(pb_oe_n), .portb_pullup(pb_pu),
    .analog_input3_sel(adc), .porta_read(pa_rd), .portb_read(pb_rd),
    .key_wake_input(kw), .irq_request(irq), .wake_request(wake),
    .spi_select_n(sel_n), .timer_channel0_in(tin),
    .spi_rx_byte(rx_byte), .spi_rx_valid(rx_v)
);
// mid-cycle sampling: the one-cycle pulse is settled here
always @(negedge core_clk) if (rx_v === 1'b1) rx_q.push_back(rx_byte);
////////////////////////////////////////////////////////////////////////
task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
endtask
task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
        bad_count++;
        $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
endtask
task automatic test_done;
    if (bad_count == 0 && checks > 0) begin
        $display("ALL TESTS PASSED");
    end else begin
        $display("TESTS FAILED");
    end
    $finish;
endtask
task automatic t_pulls;
    for (int i = 0; i < 4; i++) begin
        pa_cfg[i] = 5'h06; // pull-down asked without wake
        cyc(2);
        chk(8'(pd[i]), 8'h00);
        pa_cfg[i] = 5'h07;
        cyc(2);
        chk({6'h00, pd[i], pu[i]}, 8'h02);
        pa_cfg[i] = 5'h04;
        cyc(2);
        chk({6'h00, pd[i], pu[i]}, 8'h01);
    end
endtask
task automatic t_freeze;
    ce = 1'b0;
    pa_cfg[1] = 5'h07;
    cyc(3);
    chk({6'h00, pd[1], pu[1]}, 8'h01);
    ce = 1'b1;
    cyc(2);
    chk({6'h00, pd[1], pu[1]}, 8'h02);
    pa_cfg[1] = 5'h05;
endtask
task automatic t_wake;
    for (int i = 0; i < 4; i++) pa_cfg[i] = 5'h05;
    irq_enable = 1'b1;
    pa_pin = 4'hA;
    cyc(4);
    chk(8'(kw), 8'h0A);
    chk(8'(pa_rd), 8'h0A);
    chk({5'h00, irq, wake, sel_n}, 8'h07);
    irq_enable = 1'b0;
    cyc(2);
    chk(8'(irq), 8'h00);
    pa_pin = 4'hF;
endtask
task automatic t_portb;
    pb_cfg = '{1'b1, 1'b1, 1'b1, ppfm_pkg::PPFM_PB_GPIO};
    cyc(2);
    chk({5'h00, pb_oe_n, pb_out, adc}, 8'h02);
    pb_cfg.drive = 1'b0;
    pb_pin = 1'b0;
    cyc(4);
    chk({5'h00, pb_oe_n, pb_pu, pb_rd}, 8'h06);
    pb_cfg.func = ppfm_pkg::PPFM_PB_TIMER;
    pb_pin = 1'b1;
    cyc(4);
    chk({6'h00, pb_oe_n, tin}, 8'h03);
    {t_out, t_oe} = 2'h3;
    cyc(2);
    chk({6'h00, pb_oe_n, pb_out}, 8'h01);
    pb_cfg.func = ppfm_pkg::PPFM_PB_ADC;
    cyc(2);
    chk({5'h00, pb_oe_n, pb_pu, adc}, 8'h05);
endtask
task automatic t_spi;
    pa_cfg[0] = 5'h1C; // drives line 0 once the port is released
    spi_enable = 1'b1;
    cyc(4);
    chk(8'(oe_n), 8'h0F);
    fork
        ppfm_spi_host_inst.send(8'hA5);
        begin
            cyc(12);
            chk({3'h0, oe_n, pa_out[3]}, 8'h0F);
            chk({3'h0, kw, wake}, 8'h00);
        end
    join
    ppfm_spi_host_inst.send(8'hFF, 3);
    ppfm_spi_host_inst.send(8'h3C);
    cyc(6);
    chk(8'(rx_q.size()), 8'h02);
    chk(rx_q[0], 8'hA5);
    chk(rx_q[1], 8'h3C);
    spi_enable = 1'b0;
    cyc(2);
    chk(8'(oe_n), 8'h0E);
endtask
initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
end
initial begin
    #100000 bad_count++;
    test_done;
end
initial begin
    {reset_n, spi_enable, irq_enable, t_out, t_oe} = 5'h00;
    so_bit = 1'b1;
    pb_pin = 1'b1;
    pa_pin = 4'hF;
    pb_cfg = '{1'b0, 1'b0, 1'b1, ppfm_pkg::PPFM_PB_GPIO};
    ce = 1'b1;
    for (int i = 0; i < 4; i++) pa_cfg[i] = 5'h04;
    cyc(5);
    reset_n = 1'b1;
    cyc(4);
    t_pulls;
    t_freeze;
    t_wake;
    t_portb;
    t_spi;
    test_done;
end
endmodule
`default_nettype wire
